/* include/updown_counter_pkg.sv */
package updown_counter_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 10;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_COUNT_CONTROL_A = 5'h00;
  localparam logic [4:0] OFF_COUNT_CONTROL_B = 5'h04;
  localparam logic [4:0] OFF_SYSTEM_CONTROL_A = 5'h08;
  localparam logic [4:0] OFF_COUNT_DATA_LOW = 5'h0C;
  localparam logic [4:0] OFF_COUNT_DATA_MIDDLE = 5'h10;
  localparam logic [4:0] OFF_COUNT_DATA_HIGH = 5'h14;
  localparam logic [4:0] OFF_PRESCALER_CONTROL = 5'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_DIRECTION = 3;
  localparam int BIT_RUN = 3;
  localparam int BIT_EVENT = 2;
  localparam int BIT_COMPARE = 1;
  localparam int BIT_LOAD = 0;
  localparam int BIT_GLOBAL_IRQ = 3;
  localparam int BIT_SLEEP = 2;
  localparam int BIT_FULL_COMPARE = 1;
  localparam int BIT_PWM_ROUTE = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [9:0] COUNT_ZERO = 10'h000;

  // ----------------------------------------
  // Length select codes and masks
  // ----------------------------------------
  localparam logic [1:0] LEN_10 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_6 = 2'h2;
  localparam logic [9:0] MASK_10 = 10'h3FF;
  localparam logic [9:0] MASK_8 = 10'h0FF;
  localparam logic [9:0] MASK_6 = 10'h03F;
  localparam logic [9:0] MASK_4 = 10'h00F;

  function automatic logic [9:0] length_mask(input logic [1:0] sel);
    logic [9:0] m;
    m = MASK_4;
    if (sel == LEN_10) begin
      m = MASK_10;
    end else if (sel == LEN_8) begin
      m = MASK_8;
    end else if (sel == LEN_6) begin
      m = MASK_6;
    end
    return m;
  endfunction : length_mask

endpackage : updown_counter_pkg

/* hdl/clock_source_select.sv */
`timescale 1ns/1ps
`default_nettype none

module clock_source_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  input wire logic [7:0] sources,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic level;
  } sel_state_t;

  sel_state_t s;
  sel_state_t next_s;
  logic picked;

  // ----------------------------------------
  // Source mux and edge detect
  // ----------------------------------------
  assign picked = sources[sel];
  // Source switch may fake one edge; stop first
  assign rise = picked & ~s.level;
  assign fall = ~picked & s.level;

  always_comb begin
    next_s = s;
    next_s.level = picked;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : clock_source_select

`default_nettype wire

/* hdl/counter_terminal.sv */
`timescale 1ns/1ps
`default_nettype none

module counter_terminal (
  input wire logic [9:0] value,
  input wire logic [1:0] lengthSel,
  input wire logic countUp,
  output logic hit
);

  logic [9:0] mask;

  // ----------------------------------------
  // Terminal value per direction and length
  // ----------------------------------------
  always_comb begin
    mask = updown_counter_pkg::length_mask(lengthSel);
    if (countUp) begin
      hit = ((value & mask) == mask);
    end else begin
      // Zero within the selected length; upper bits are held, not counted
      hit = ((value & mask) == updown_counter_pkg::COUNT_ZERO);
    end
  end

endmodule : counter_terminal

`default_nettype wire

/* hdl/updown_counter.sv */
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module updown_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic portALineZero,
  input wire logic portALineThree,
  input wire logic [5:0] prescalerTaps,
  output logic terminalCountIrq,
  output logic [9:0] countValue,
  output logic running,
  output logic countUp,
  output logic compareEnable,
  output logic eventCountEnable,
  output logic pwmRouteEnable,
  output logic fullCompareSelect,
  output logic globalIrqEnable,
  output logic sleepRequest
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;

  typedef struct packed {
    logic [9:0] count;
    logic [9:0] preload;
    logic [5:0] shadow;
    logic [1:0] lengthSel;
    logic countUp;
    logic [2:0] clkSel;
    logic run;
    logic eventMode;
    logic compareEnable;
    logic [3:0] sysCtl;
    logic pwmRoute;
    logic armed;
    logic tcIrq;
    logic [31:0] readData;
    bus_state_t bus;
  } state_t;

  state_t s;
  state_t next_s;

  logic [7:0] sources;
  logic srcRise;
  logic srcFall;
  logic [9:0] mask;
  logic [9:0] stepped;
  logic step;
  logic stepHit;
  logic accept;

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // Code order: port A zero, taps 15..1, port A three
  // Tap port runs from tap 1 at bit 0 up to tap 15 at bit 5
  assign sources = {portALineThree, prescalerTaps[0], prescalerTaps[1], prescalerTaps[2],
    prescalerTaps[3], prescalerTaps[4], prescalerTaps[5], portALineZero};

  clock_source_select u_src (
    .clk(clk),
    .rst_n(rst_n),
    .sel(s.clkSel),
    .sources(sources),
    .rise(srcRise),
    .fall(srcFall)
  );

  // ----------------------------------------
  // Counting step
  // ----------------------------------------
  assign mask = updown_counter_pkg::length_mask(s.lengthSel);
  assign step = s.run & s.armed & srcRise;

  // Bits above the length stay put, lower bits wrap
  always_comb begin
    if (s.countUp) begin
      stepped = (s.count & ~mask) | ((s.count + 10'h001) & mask);
    end else begin
      stepped = (s.count & ~mask) | ((s.count - 10'h001) & mask);
    end
  end

  counter_terminal u_term (
    .value(stepped),
    .lengthSel(s.lengthSel),
    .countUp(s.countUp),
    .hit(stepHit)
  );

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state so read data come from a register
  assign waitrequest = (read | write) & (s.bus != BUS_ACK);
  assign accept = (s.bus == BUS_ACK) & (read | write);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.tcIrq = 1'b0;

    // Start sync: first count after a seen low phase; event mode arms at once
    if (!s.run) begin
      next_s.armed = 1'b0;
    end else if (s.eventMode | srcFall) begin
      next_s.armed = 1'b1;
    end

    if (step) begin
      next_s.count = stepped;
      next_s.tcIrq = stepHit;
    end

    case (s.bus)
      BUS_IDLE: begin
        if (read | write) begin
          next_s.bus = BUS_ACK;
        end
        if (read) begin
          next_s.readData = '0;
          if (address == updown_counter_pkg::OFF_COUNT_CONTROL_A) begin
            next_s.readData[3:0] = {s.countUp, s.clkSel};
          end else if (address == updown_counter_pkg::OFF_COUNT_CONTROL_B) begin
            // Load strobe never reads back
            next_s.readData[3:0] = {s.run, s.eventMode, s.compareEnable, 1'b0};
          end else if (address == updown_counter_pkg::OFF_SYSTEM_CONTROL_A) begin
            next_s.readData[3:0] = s.sysCtl;
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_LOW) begin
            next_s.readData[3:0] = s.count[3:0];
            // Same edge as the nibble, so all three reads agree
            next_s.shadow = s.count[9:4];
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_MIDDLE) begin
            next_s.readData[3:0] = s.shadow[3:0];
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_HIGH) begin
            next_s.readData[3:0] = {s.lengthSel, s.shadow[5:4]};
          end else if (address == updown_counter_pkg::OFF_PRESCALER_CONTROL) begin
            next_s.readData[updown_counter_pkg::BIT_PWM_ROUTE] = s.pwmRoute;
          end
        end
      end
      BUS_ACK: begin
        next_s.bus = BUS_IDLE;
        if (write) begin
          if (address == updown_counter_pkg::OFF_COUNT_CONTROL_A) begin
            next_s.countUp = writedata[updown_counter_pkg::BIT_DIRECTION];
            next_s.clkSel = writedata[2:0];
            if (writedata[updown_counter_pkg::BIT_DIRECTION] != s.countUp) begin
              // Inversion wins over a step in the same cycle
              next_s.count = ~s.count;
              next_s.tcIrq = 1'b0;
            end
          end else if (address == updown_counter_pkg::OFF_COUNT_CONTROL_B) begin
            next_s.run = writedata[updown_counter_pkg::BIT_RUN];
            next_s.eventMode = writedata[updown_counter_pkg::BIT_EVENT];
            next_s.compareEnable = writedata[updown_counter_pkg::BIT_COMPARE];
            if (writedata[updown_counter_pkg::BIT_LOAD]) begin
              next_s.count = s.preload;
              next_s.compareEnable = 1'b0;
              next_s.armed = 1'b0;
              next_s.tcIrq = 1'b0;
              if (s.preload == updown_counter_pkg::COUNT_ZERO) begin
                next_s.run = 1'b0;
              end
            end
          end else if (address == updown_counter_pkg::OFF_SYSTEM_CONTROL_A) begin
            next_s.sysCtl = writedata[3:0];
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_LOW) begin
            next_s.preload[3:0] = writedata[3:0];
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_MIDDLE) begin
            next_s.preload[7:4] = writedata[3:0];
          end else if (address == updown_counter_pkg::OFF_COUNT_DATA_HIGH) begin
            next_s.lengthSel = writedata[3:2];
            next_s.preload[9:8] = writedata[1:0];
          end else if (address == updown_counter_pkg::OFF_PRESCALER_CONTROL) begin
            next_s.pwmRoute = writedata[updown_counter_pkg::BIT_PWM_ROUTE];
          end
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.count <= updown_counter_pkg::RST_COUNT;
      s.preload <= updown_counter_pkg::RST_COUNT;
      s.shadow <= '0;
      s.lengthSel <= updown_counter_pkg::LEN_10;
      s.countUp <= 1'b0;
      s.clkSel <= '0;
      s.run <= 1'b0;
      s.eventMode <= 1'b0;
      s.compareEnable <= 1'b0;
      s.sysCtl <= updown_counter_pkg::RST_NIBBLE;
      s.pwmRoute <= 1'b0;
      s.armed <= 1'b0;
      s.tcIrq <= 1'b0;
      s.readData <= '0;
      s.bus <= BUS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign readdata = s.readData;
  assign terminalCountIrq = s.tcIrq;
  assign countValue = s.count;
  assign running = s.run;
  assign countUp = s.countUp;
  assign compareEnable = s.compareEnable;
  assign eventCountEnable = s.eventMode;
  assign pwmRouteEnable = s.pwmRoute;
  assign fullCompareSelect = s.sysCtl[updown_counter_pkg::BIT_FULL_COMPARE];
  assign globalIrqEnable = s.sysCtl[updown_counter_pkg::BIT_GLOBAL_IRQ];
  assign sleepRequest = s.sysCtl[updown_counter_pkg::BIT_SLEEP];

  // Accept is the edge where writes land and reads are taken
  logic unusedAccept;
  assign unusedAccept = accept;

endmodule : updown_counter

`default_nettype wire

/* dv/updown_counter_props.sv */
`timescale 1ns/1ps
`default_nettype none
module updown_counter_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic terminalCountIrq,
  input wire logic [9:0] countValue,
  input wire logic running,
  input wire logic countUp,
  input wire logic compareEnable
);
  // ----------
  // Helper state
  // ----------
  logic [9:0] pre;
  logic [1:0] len;
  wire logic done = write && !waitrequest;
  wire logic ld = done && address == 5'h04 && writedata[0];
  wire logic [9:0] m = 10'h3FF >> (2 * len);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 10'h000;
      len <= 2'h0;
    end else if (done) begin
      if (address == 5'h0C) pre[3:0] <= writedata[3:0];
      if (address == 5'h10) pre[7:4] <= writedata[3:0];
      if (address == 5'h14) {len, pre[9:8]} <= writedata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Properties
  // ----------
  chk_load_copy: assert property (ld |=> countValue == pre)
    else $error("load did not copy preload");
  chk_load_cmp: assert property (ld |=> !compareEnable)
    else $error("load left compare enabled");
  chk_load_noirq: assert property (ld |=> ##1 !terminalCountIrq)
    else $error("load raised terminal irq");
  chk_zero_stop: assert property (ld && pre == 10'h000 |=> !running)
    else $error("zero load kept running");
  chk_dir_invert: assert property (done && address == 5'h00 && writedata[3] != countUp
    |=> countValue == ~$past(countValue))
    else $error("direction change did not invert");
  // Any change not caused by a bus write must be one step within the length
  chk_step_size: assert property (!$past(done) && countValue != $past(countValue)
    |-> ((countValue ^ $past(countValue)) & ~m) == 10'h000
    && ((countValue - $past(countValue)) & m) == ((countUp ? 10'h001 : 10'h3FF) & m))
    else $error("count moved by other than one step");
  chk_irq_term: assert property (terminalCountIrq
    |-> (countValue & m) == (countUp ? m : 10'h000))
    else $error("terminal irq away from terminal");
  chk_stop_hold: assert property (!running && !done |=> $stable(countValue))
    else $error("count moved while stopped");
endmodule : updown_counter_props
bind updown_counter updown_counter_props updown_counter_props_inst (.clk, .rst_n, .address,
  .write, .writedata, .waitrequest, .terminalCountIrq, .countValue, .running, .countUp,
  .compareEnable);
`default_nettype wire

/* dv/updown_counter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module updown_counter_bench;
  logic clk = 0, rst_n = 0, read = 0, write = 0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rd, r;
  logic waitrequest, terminalCountIrq, running, countUp, compareEnable;
  logic eventCountEnable, pwmRouteEnable, fullCompareSelect, globalIrqEnable, sleepRequest;
  logic [9:0] countValue, mdl, m;
  logic [7:0] src = 8'h00;
  int error_cnt = 0, tests_run = 0, irqCnt = 0, irqExp = 0;
  updown_counter updown_counter_inst (.clk, .rst_n, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .portALineZero(src[0]), .portALineThree(src[7]),
    .prescalerTaps({src[1], src[2], src[3], src[4], src[5], src[6]}), .terminalCountIrq,
    .countValue, .running, .countUp, .compareEnable, .eventCountEnable, .pwmRouteEnable,
    .fullCompareSelect, .globalIrqEnable, .sleepRequest);
  initial forever #5 clk = ~clk;
  // Mid-cycle sampling keeps the pulse count free of edge races
  always @(negedge clk) if (terminalCountIrq === 1'b1) irqCnt++;
  // ----------
  // Bus and source tasks
  // ----------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    #1;
    while (waitrequest !== 1'b0 && t < 40) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t == 40) error_cnt++;
    @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    #1;
  endtask : bus
  task automatic pulse(input int i);
    @(posedge clk);
    src[i] <= 1'b1;
    repeat (3) @(posedge clk);
    src[i] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  task automatic step(input logic up);
    mdl = (mdl & ~m) | ((mdl + (up ? 10'h001 : 10'h3FF)) & m);
    if ((mdl & m) == (up ? m : 10'h000)) irqExp++;
  endtask : step
  task automatic run_case(input int c, input logic up, input logic [1:0] len,
    input logic [9:0] pre, input int n);
    logic [9:0] sh;
    m = 10'h3FF >> (2 * len);
    bus(1, 5'h04, 32'h0);
    bus(1, 5'h00, {up, c[2:0]});
    bus(1, 5'h0C, pre[3:0]);
    bus(1, 5'h10, pre[7:4]);
    bus(1, 5'h14, {len, pre[9:8]});
    bus(1, 5'h04, 32'hF);
    mdl = pre;
    `CHK("cmpEn", 1'b0, compareEnable)
    `CHK("run", pre != 10'h000, running)
    bus(0, 5'h04, 32'h0);
    `CHK("ctlB", pre != 10'h000 ? 32'hC : 32'h4, rd)
    for (int i = 0; i < n; i++) begin
      pulse(c);
      if (pre != 10'h000) step(up);
      pulse((c + 1) % 8);
    end
    sh = mdl;
    bus(0, 5'h0C, 32'h0);
    `CHK("low", {28'h0, sh[3:0]}, rd)
    pulse(c);
    if (pre != 10'h000) step(up);
    bus(0, 5'h10, 32'h0);
    `CHK("mid", {28'h0, sh[7:4]}, rd)
    bus(0, 5'h14, 32'h0);
    `CHK("high", {28'h0, len, sh[9:8]}, rd)
    `CHK("count", mdl, countValue)
    `CHK("irqs", irqExp, irqCnt)
    bus(1, 5'h00, {!up, c[2:0]});
    mdl = ~mdl;
    `CHK("invert", mdl, countValue)
    $display("test case %0d done", c);
  endtask : run_case
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ----------
  // Sequence
  // ----------
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(78));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(0, 5'(i * 4), 32'h0);
      `CHK("reset", 32'h0, rd)
    end
    bus(1, 5'h1C, 32'hF);
    bus(0, 5'h1C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    repeat (4) begin
      r = $urandom;
      bus(1, 5'h08, r);
      bus(0, 5'h08, 32'h0);
      `CHK("sysA", {28'h0, r[3:0]}, rd)
      `CHK("sysPorts", r[3:1], {globalIrqEnable, sleepRequest, fullCompareSelect})
      bus(1, 5'h00, r);
      bus(0, 5'h00, 32'h0);
      `CHK("ctlA", {28'h0, r[3:0]}, rd)
      `CHK("dir", r[3], countUp)
      bus(1, 5'h04, r & 32'hE);
      bus(0, 5'h04, 32'h0);
      `CHK("ctlB", r & 32'hE, rd)
      `CHK("ctlPorts", r[3:1], {running, eventCountEnable, compareEnable})
      bus(1, 5'h18, r & 32'h1);
      `CHK("pwm", r[0], pwmRouteEnable)
    end
    $display("test registers done");
    for (int c = 0; c < 8; c++) run_case(c, c[0], 2'($urandom), 10'($urandom), 1 + $urandom % 3);
    run_case(7, 1, 3, 10'h2FD, 4);
    run_case(1, 0, 0, 10'h002, 3);
    run_case(2, 1, 0, 10'h3FE, 2);
    run_case(3, 0, 2, 10'h000, 2);
    tally_and_finish();
  end
endmodule : updown_counter_bench
`default_nettype wire
